// File: hdl/boc_pkg.sv
// package of register map, field layout and carriers for the blit register bank
package boc_pkg;

	// host window offset width; the blit bank sits 4 MB into the window
	localparam int          BOC_AW            = 23;
	localparam logic [22:0] BOC_BLIT_BASE     = 23'h400000;
	localparam logic [22:0] BOC_LAST_OFFSET   = 23'h000028;

	// register byte addresses inside the host window
	localparam logic [22:0] BOC_ADDR_LINE_OFS = 23'h400000;
	localparam logic [22:0] BOC_ADDR_SH_BG    = 23'h400004;
	localparam logic [22:0] BOC_ADDR_SH_FG    = 23'h400008;
	localparam logic [22:0] BOC_ADDR_MONO     = 23'h40000C;
	localparam logic [22:0] BOC_ADDR_CTRL     = 23'h400010;
	localparam logic [22:0] BOC_ADDR_PAT      = 23'h400014;
	localparam logic [22:0] BOC_ADDR_SRC      = 23'h400018;
	localparam logic [22:0] BOC_ADDR_DST      = 23'h40001C;
	localparam logic [22:0] BOC_ADDR_EXTENT   = 23'h400020;
	localparam logic [22:0] BOC_ADDR_SRC_BG   = 23'h400024;
	localparam logic [22:0] BOC_ADDR_SRC_FG   = 23'h400028;

	// register indices (byte address bits 5:2 above the base)
	localparam int          BOC_NREGS         = 11;
	localparam logic [3:0]  BOC_IDX_LINE_OFS  = 4'h0;
	localparam logic [3:0]  BOC_IDX_SH_BG     = 4'h1;
	localparam logic [3:0]  BOC_IDX_SH_FG     = 4'h2;
	localparam logic [3:0]  BOC_IDX_MONO      = 4'h3;
	localparam logic [3:0]  BOC_IDX_CTRL      = 4'h4;
	localparam logic [3:0]  BOC_IDX_PAT       = 4'h5;
	localparam logic [3:0]  BOC_IDX_SRC       = 4'h6;
	localparam logic [3:0]  BOC_IDX_DST       = 4'h7;
	localparam logic [3:0]  BOC_IDX_EXTENT    = 4'h8;
	localparam logic [3:0]  BOC_IDX_SRC_BG    = 4'h9;
	localparam logic [3:0]  BOC_IDX_SRC_FG    = 4'hA;

	// writable-bit masks; cleared positions other than the control busy bit are reserved and read zero
	localparam logic [31:0] BOC_MASK_OFFSETS  = 32'h1FFF1FFF;
	localparam logic [31:0] BOC_MASK_COLOR    = 32'h00FFFFFF;
	localparam logic [31:0] BOC_MASK_MONO     = 32'h0F3F3F3F;
	localparam logic [31:0] BOC_MASK_CTRL     = 32'h03FFFFFF;
	localparam logic [31:0] BOC_MASK_FULL     = 32'hFFFFFFFF;
	localparam logic [31:0] BOC_REG_RESET     = 32'h00000000;

	// field positions
	localparam int          BOC_DST_OFS_LSB   = 16;
	localparam int          BOC_OFS_W         = 13;
	localparam int          BOC_COLOR_W       = 24;
	localparam int          BOC_SRC_SEL_BIT   = 27;
	localparam int          BOC_BUSY_BIT      = 31;
	localparam int          BOC_DEPTH_OVR_BIT = 23;
	localparam int          BOC_DEPTH_LSB     = 24;

	// byte-lane patterns of the two legal access sizes
	localparam logic [3:0]  BOC_BE_LOW_WORD   = 4'h3;
	localparam logic [3:0]  BOC_BE_HIGH_WORD  = 4'hC;
	localparam logic [3:0]  BOC_BE_DWORD      = 4'hF;

	// colour depth codes and the colour bytes each one uses
	localparam logic [1:0]  BOC_DEPTH_8       = 2'h0;
	localparam logic [1:0]  BOC_DEPTH_16      = 2'h1;
	localparam logic [23:0] BOC_CMASK_8       = 24'h0000FF;
	localparam logic [23:0] BOC_CMASK_16      = 24'h00FFFF;
	localparam logic [23:0] BOC_CMASK_24      = 24'hFFFFFF;

	// one host access, presented for a single cycle
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [22:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} boc_host_req_t;

	// settings handed to the drawing datapath
	typedef struct packed {
		logic [23:0] patBg;
		logic [23:0] patFg;
		logic [23:0] srcBg;
		logic [23:0] srcFg;
		logic [12:0] dstPitch;
		logic [12:0] srcPitch;
	} boc_engine_cfg_t;

endpackage

// File: hdl/boc_regs.sv
// blit register bank: host decode, offsets, expansion colours, line stepping
`timescale 1ns/10ps
`default_nettype none
// How it works
// - bank decoded 4 MB above window base
// - eleven consecutive word-spaced registers decoded
// - word or doubleword host accesses accepted
// - reserved offset and colour bits read zero
// - frame buffer: destination address steps by offset
// - host destination: offset is line pitch bytes
// - source offset ignored unless colour source
// - frame buffer source: address steps by offset
// - host source: offset is line pitch bytes
// - shared background feeds pattern, maybe source
// - select set: source background from own register
// - depth picks one, two or three bytes
// - shared foreground feeds pattern, maybe source
// - select bit routes source expansion colours
module boc_regs (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst_b,
	// host register access
	input  wire boc_pkg::boc_host_req_t    hostReq,
	output logic                           hostAck,
	output logic [31:0]                    hostRdata,
	// engine status and configuration
	input  wire logic                      engineBusy,
	input  wire logic [1:0]                cfgDepth,
	input  wire logic                      srcIsColor,
	// line stepping strobes from the engine
	input  wire logic                      blitStart,
	input  wire logic                      dstLineStep,
	input  wire logic                      srcLineStep,
	// settings and line addresses to the engine
	output boc_pkg::boc_engine_cfg_t       engineCfg,
	output logic [31:0]                    dstLineAddr,
	output logic [31:0]                    srcLineAddr
);
	import boc_pkg::*;

	logic [31:0]     regFile      [BOC_NREGS];
	logic [31:0]     next_regFile [BOC_NREGS];
	logic            next_hostAck;
	logic [31:0]     next_hostRdata;
	boc_engine_cfg_t next_engineCfg;
	logic [31:0]     next_dstLineAddr;
	logic [31:0]     next_srcLineAddr;
	logic [4:0]      decoded;
	logic            hit;
	logic [3:0]      idx;
	logic            legalSize;
	logic [1:0]      depth;
	logic [23:0]     colorMask;
	logic            srcSel;

	// address decode: {hit, index}; misaligned or outside the bank misses
	function automatic logic [4:0] decodeAddr(input logic [22:0] a);
		logic [22:0] off;
		off = a - BOC_BLIT_BASE;
		if (a[1:0] != 2'h0) begin
			return 5'h00;
		end else if (a < BOC_BLIT_BASE) begin
			return 5'h00;
		end else if (off > BOC_LAST_OFFSET) begin
			return 5'h00;
		end else begin
			return {1'b1, off[5:2]};
		end
	endfunction

	// implemented bits of each register
	function automatic logic [31:0] regMask(input logic [3:0] i);
		if (i == BOC_IDX_LINE_OFS) begin
			return BOC_MASK_OFFSETS;
		end else if (i == BOC_IDX_SH_BG || i == BOC_IDX_SH_FG) begin
			return BOC_MASK_COLOR;
		end else if (i == BOC_IDX_SRC_BG || i == BOC_IDX_SRC_FG) begin
			return BOC_MASK_COLOR;
		end else if (i == BOC_IDX_MONO) begin
			return BOC_MASK_MONO;
		end else if (i == BOC_IDX_CTRL) begin
			return BOC_MASK_CTRL;
		end else begin
			return BOC_MASK_FULL;
		end
	endfunction

	// colour bytes in use at a given depth
	function automatic logic [23:0] depthMask(input logic [1:0] d);
		case (d)
			BOC_DEPTH_8:  return BOC_CMASK_8;
			BOC_DEPTH_16: return BOC_CMASK_16;
			default:      return BOC_CMASK_24;
		endcase
	endfunction

	// decode the current access once for every register slice
	always_comb begin
		decoded   = decodeAddr(hostReq.addr);
		hit       = decoded[4];
		idx       = decoded[3:0];
		legalSize = (hostReq.be == BOC_BE_LOW_WORD)
			|| (hostReq.be == BOC_BE_HIGH_WORD)
			|| (hostReq.be == BOC_BE_DWORD);
	end

	// per-register write merge; a half changes only when both its lanes
	// are enabled, so odd byte patterns cannot tear a field
	generate
		for (genvar g = 0; g < BOC_NREGS; g++) begin : gRegs
			always_comb begin
				next_regFile[g] = regFile[g];
				if (hostReq.sel && hostReq.wr && hit && legalSize
					&& idx == 4'(g)) begin
					if (hostReq.be[1:0] == 2'h3) begin
						next_regFile[g][15:0] = hostReq.wdata[15:0];
					end
					if (hostReq.be[3:2] == 2'h3) begin
						next_regFile[g][31:16] = hostReq.wdata[31:16];
					end
					next_regFile[g] = next_regFile[g] & regMask(4'(g));
				end
			end
		end
	endgenerate

	// host answer: every selected cycle is acknowledged one cycle later;
	// misses and illegal sizes read zero and write nothing
	always_comb begin
		next_hostAck   = hostReq.sel;
		next_hostRdata = 32'h00000000;
		if (hostReq.sel && !hostReq.wr && hit && legalSize) begin
			next_hostRdata = regFile[idx] & regMask(idx);
			if (idx == BOC_IDX_CTRL) begin
				next_hostRdata[BOC_BUSY_BIT] = engineBusy;
			end
		end
	end

	// effective depth: control override or the configuration setting
	always_comb begin
		if (regFile[BOC_IDX_CTRL][BOC_DEPTH_OVR_BIT]) begin
			depth = regFile[BOC_IDX_CTRL][BOC_DEPTH_LSB +: 2];
		end else begin
			depth = cfgDepth;
		end
		colorMask = depthMask(depth);
		srcSel    = regFile[BOC_IDX_MONO][BOC_SRC_SEL_BIT];
	end

	// engine settings, registered so the datapath sees clean levels
	always_comb begin
		next_engineCfg.patBg = regFile[BOC_IDX_SH_BG][23:0] & colorMask;
		next_engineCfg.patFg = regFile[BOC_IDX_SH_FG][23:0] & colorMask;
		if (srcSel) begin
			next_engineCfg.srcBg = regFile[BOC_IDX_SRC_BG][23:0] & colorMask;
			next_engineCfg.srcFg = regFile[BOC_IDX_SRC_FG][23:0] & colorMask;
		end else begin
			next_engineCfg.srcBg = regFile[BOC_IDX_SH_BG][23:0] & colorMask;
			next_engineCfg.srcFg = regFile[BOC_IDX_SH_FG][23:0] & colorMask;
		end
		next_engineCfg.dstPitch =
			regFile[BOC_IDX_LINE_OFS][BOC_DST_OFS_LSB +: BOC_OFS_W];
		// a mono or absent source must not see a stale pitch
		if (srcIsColor) begin
			next_engineCfg.srcPitch =
				regFile[BOC_IDX_LINE_OFS][BOC_OFS_W-1:0];
		end else begin
			next_engineCfg.srcPitch = 13'h0000;
		end
	end

	// line address stepping; the same sum serves frame buffer addresses
	// and host byte counts, only the start value differs in meaning
	always_comb begin
		next_dstLineAddr = dstLineAddr;
		next_srcLineAddr = srcLineAddr;
		if (blitStart) begin
			next_dstLineAddr = regFile[BOC_IDX_DST];
			next_srcLineAddr = regFile[BOC_IDX_SRC];
		end else begin
			if (dstLineStep) begin
				next_dstLineAddr = dstLineAddr
					+ {19'h00000, engineCfg.dstPitch};
			end
			// raw field here: the registered pitch lags a change of
			// source kind by a cycle and would drop the first colour step
			if (srcLineStep && srcIsColor) begin
				next_srcLineAddr = srcLineAddr + {19'h00000,
					regFile[BOC_IDX_LINE_OFS][BOC_OFS_W-1:0]};
			end
		end
	end

	// all state registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < BOC_NREGS; i++) begin
				regFile[i] <= BOC_REG_RESET;
			end
			hostAck     <= 1'b0;
			hostRdata   <= 32'h00000000;
			engineCfg   <= '0;
			dstLineAddr <= 32'h00000000;
			srcLineAddr <= 32'h00000000;
		end else begin
			for (int i = 0; i < BOC_NREGS; i++) begin
				regFile[i] <= next_regFile[i];
			end
			hostAck     <= next_hostAck;
			hostRdata   <= next_hostRdata;
			engineCfg   <= next_engineCfg;
			dstLineAddr <= next_dstLineAddr;
			srcLineAddr <= next_srcLineAddr;
		end
	end

	// checks on the bank's own behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_rdAt(logic [22:0] a);
		hostReq.sel && !hostReq.wr && hostReq.addr == a
			&& hostReq.be == BOC_BE_DWORD;
	endsequence

	sequence s_wrDword(logic [22:0] a);
		hostReq.sel && hostReq.wr && hostReq.addr == a
			&& hostReq.be == BOC_BE_DWORD;
	endsequence

	property p_missReadsZero;
		hostReq.sel && !hostReq.wr && !hit |=> hostAck && hostRdata == 0;
	endproperty
	a_missReadsZero: assert property (p_missReadsZero)
		else $error("unmapped read did not return zero");

	property p_offsetReserved;
		s_rdAt(BOC_ADDR_LINE_OFS)
			|=> hostRdata[31:29] == 3'h0 && hostRdata[15:13] == 3'h0;
	endproperty
	a_offsetReserved: assert property (p_offsetReserved)
		else $error("offset reserved bits read nonzero");

	property p_colorTopByte;
		s_rdAt(BOC_ADDR_SRC_FG) or s_rdAt(BOC_ADDR_SH_BG)
			|=> hostRdata[31:24] == 8'h00;
	endproperty
	a_colorTopByte: assert property (p_colorTopByte)
		else $error("colour top byte read nonzero");

	property p_writeThenRead;
		s_wrDword(BOC_ADDR_SRC_BG) ##1 !hostReq.sel ##1 s_rdAt(BOC_ADDR_SRC_BG)
			|=> hostRdata == ($past(hostReq.wdata, 3) & BOC_MASK_COLOR);
	endproperty
	a_writeThenRead: assert property (p_writeThenRead)
		else $error("colour register read back wrong");

	property p_lowWordKeepsHigh;
		hostReq.sel && hostReq.wr && hostReq.be == BOC_BE_LOW_WORD
			&& hostReq.addr == BOC_ADDR_LINE_OFS
			|=> regFile[BOC_IDX_LINE_OFS][31:16]
				== $past(regFile[BOC_IDX_LINE_OFS][31:16]);
	endproperty
	a_lowWordKeepsHigh: assert property (p_lowWordKeepsHigh)
		else $error("word write disturbed the other half");

	property p_monoSrcNoPitch;
		!srcIsColor |=> engineCfg.srcPitch == 13'h0000;
	endproperty
	a_monoSrcNoPitch: assert property (p_monoSrcNoPitch)
		else $error("source pitch leaked for mono source");

	property p_dstStep;
		dstLineStep && !blitStart
			|=> dstLineAddr == $past(dstLineAddr)
				+ {19'h00000, $past(engineCfg.dstPitch)};
	endproperty
	a_dstStep: assert property (p_dstStep)
		else $error("destination line step wrong");

	property p_srcStep;
		srcLineStep && srcIsColor && !blitStart
			|=> srcLineAddr == $past(srcLineAddr) + {19'h00000,
				$past(regFile[BOC_IDX_LINE_OFS][BOC_OFS_W-1:0])};
	endproperty
	a_srcStep: assert property (p_srcStep)
		else $error("source line step wrong");

	property p_srcHold;
		srcLineStep && !srcIsColor && !blitStart
			|=> srcLineAddr == $past(srcLineAddr);
	endproperty
	a_srcHold: assert property (p_srcHold)
		else $error("source line moved for mono source");

	property p_srcRouting;
		srcSel |=> engineCfg.srcBg
			== ($past(regFile[BOC_IDX_SRC_BG][23:0]) & $past(colorMask));
	endproperty
	a_srcRouting: assert property (p_srcRouting)
		else $error("source background not from its own register");

	property p_depth8;
		depth == BOC_DEPTH_8 ##1 depth == BOC_DEPTH_8
			|-> engineCfg.patFg[23:8] == 16'h0000;
	endproperty
	a_depth8: assert property (p_depth8)
		else $error("upper colour bytes used at 8 bpp");

endmodule
`default_nettype wire

// File: dv/boc_host_model.sv
// host processor model issuing one-cycle requests to the blit register bank
`timescale 1ns/10ps
`default_nettype none
module boc_host_model (
	// clock
	input  wire logic               core_clk,
	// request and answer
	output var boc_pkg::boc_host_req_t hostReq,
	input  wire logic               hostAck,
	input  wire logic [31:0]        hostRdata
);
	import boc_pkg::*;
	// idle bus at time zero
	initial hostReq = '0;
	// one access; gap idles first, so both prompt and slow hosts are seen
	task automatic access(input logic wr, input logic [22:0] addr,
		input logic [3:0] be, input logic [31:0] wd, input int gap,
		output logic [31:0] rd, output logic ack);
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		hostReq <= '{1'b1, wr, addr, be, wd};
		@(posedge core_clk);
		// released lines show the inverse, never a stale copy
		hostReq <= '{1'b0, ~wr, ~addr, ~be, ~wd};
		#1;
		ack = hostAck;
		rd = hostRdata;
	endtask
endmodule
`default_nettype wire

// File: dv/blit_offset_color_regs_test.sv
// self-checking bench for the blit register bank
`timescale 1ns/10ps
`default_nettype none
module blit_offset_color_regs_test;
	import boc_pkg::*;
	logic            core_clk = 1'b0;
	logic            rst_b = 1'b0;
	boc_host_req_t   hostReq;
	logic            hostAck;
	logic [31:0]     hostRdata;
	logic            engineBusy = 1'b0;
	logic [1:0]      cfgDepth = 2'h0;
	logic            srcIsColor = 1'b0;
	logic            blitStart = 1'b0;
	logic            dstLineStep = 1'b0;
	logic            srcLineStep = 1'b0;
	boc_engine_cfg_t engineCfg;
	logic [31:0]     dstLineAddr;
	logic [31:0]     srcLineAddr;
	int              num_errors = 0;
	int              compares = 0;
	int              cycles = 0;
	int              seed = 2;
	logic [31:0]     mdl [BOC_NREGS] = '{default: '0};
	logic [31:0]     rd;
	logic            ack;
	logic [31:0]     dst;
	logic [31:0]     src;
	logic [26:0]     bad [4] = '{{23'h400002, 4'hF}, {23'h40002C, 4'hF},
		{23'h3FFFFC, 4'hF}, {23'h400004, 4'h1}};

	boc_regs u_boc_regs (.core_clk(core_clk), .rst_b(rst_b),
		.hostReq(hostReq), .hostAck(hostAck), .hostRdata(hostRdata),
		.engineBusy(engineBusy), .cfgDepth(cfgDepth),
		.srcIsColor(srcIsColor), .blitStart(blitStart),
		.dstLineStep(dstLineStep), .srcLineStep(srcLineStep),
		.engineCfg(engineCfg), .dstLineAddr(dstLineAddr),
		.srcLineAddr(srcLineAddr));
	boc_host_model u_boc_host_model (.core_clk(core_clk),
		.hostReq(hostReq), .hostAck(hostAck), .hostRdata(hostRdata));

	// 200 MHz clock
	always #2.5 core_clk = ~core_clk;

	// hang guard; the whole run needs under a thousand cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [135:0] seen, input logic [135:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// writable bits of each register; the rest, bar the control busy bit, read zero
	function automatic logic [31:0] msk(input int i);
		case (i)
			0: return BOC_MASK_OFFSETS;
			1, 2, 9, 10: return BOC_MASK_COLOR;
			3: return BOC_MASK_MONO;
			4: return BOC_MASK_CTRL;
			default: return BOC_MASK_FULL;
		endcase
	endfunction

	// write through the host and mirror the lanes it covers
	task automatic wr(input int i, input logic [3:0] be, input logic [31:0] d);
		logic [31:0] lm;
		lm = {{16{be[3]}}, {16{be[1]}}};
		u_boc_host_model.access(1'b1, BOC_BLIT_BASE + 23'(i * 4), be, d,
			$random(seed) & 1, rd, ack);
		mdl[i] = ((mdl[i] & ~lm) | (d & lm)) & msk(i);
		chk(ack, 1'b1);
		chk(rd, 32'h0);
	endtask

	// read back; busy shows in the control word only
	task automatic rdchk(input int i);
		u_boc_host_model.access(1'b0, BOC_BLIT_BASE + 23'(i * 4), 4'hF,
			32'h0, 0, rd, ack);
		chk(ack, 1'b1);
		chk(rd, mdl[i] | ((i == 4) ? {engineBusy, 31'h0} : 32'h0));
	endtask

	// settings seen by the engine two cycles after the last change
	task automatic cfgchk();
		boc_engine_cfg_t e;
		logic [1:0]      d;
		logic [23:0]     cm;
		int              sb;
		repeat (2) @(posedge core_clk);
		#1;
		d = mdl[4][23] ? mdl[4][25:24] : cfgDepth;
		cm = (d == 0) ? BOC_CMASK_8 : (d == 1) ? BOC_CMASK_16 : BOC_CMASK_24;
		sb = mdl[3][27] ? 9 : 1;
		e.patBg = mdl[1][23:0] & cm;
		e.patFg = mdl[2][23:0] & cm;
		e.srcBg = mdl[sb][23:0] & cm;
		e.srcFg = mdl[sb + 1][23:0] & cm;
		e.dstPitch = mdl[0][28:16];
		e.srcPitch = srcIsColor ? mdl[0][12:0] : 13'h0;
		chk(engineCfg, e);
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		// everything clears out of reset
		for (int i = 0; i < BOC_NREGS; i++)
			rdchk(i);
		cfgchk();
		// random writes in all three byte-lane patterns, each read back
		for (int k = 0; k < 66; k++) begin
			@(posedge core_clk);
			engineBusy <= 1'($random(seed));
			cfgDepth <= 2'($random(seed));
			srcIsColor <= 1'($random(seed));
			wr(k % BOC_NREGS, (k % 3 == 0) ? 4'h3 : (k % 3 == 1) ? 4'hC : 4'hF,
				$random(seed));
			rdchk(k % BOC_NREGS);
			cfgchk();
		end
		// refused: misaligned, beyond, below, odd lanes
		foreach (bad[j]) begin
			u_boc_host_model.access(1'b1, bad[j][26:4], bad[j][3:0],
				32'hFFFFFFFF, 0, rd, ack);
			chk(ack, 1'b1);
			u_boc_host_model.access(1'b0, bad[j][26:4], bad[j][3:0], 32'h0, 0,
				rd, ack);
			chk(ack, 1'b1);
			chk(rd, 32'h0);
		end
		for (int i = 0; i < BOC_NREGS; i++)
			rdchk(i);
		// pitch programmed as bytes per line, then stepped across a wrap
		wr(0, 4'hF, 32'hFABC1234);
		wr(7, 4'hF, 32'hFFFFF800);
		@(posedge core_clk);
		blitStart <= 1'b1;
		dstLineStep <= 1'b1;
		dst = mdl[7];
		src = mdl[6];
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			blitStart <= 1'b0;
			srcLineStep <= 1'b1;
			srcIsColor <= k[0];
			#1;
			chk(dstLineAddr, dst);
			chk(srcLineAddr, src);
			dst = dst + mdl[0][28:16];
			src = src + (k[0] ? mdl[0][12:0] : 13'h0);
		end
		@(posedge core_clk);
		dstLineStep <= 1'b0;
		srcLineStep <= 1'b0;
		#1;
		chk(dstLineAddr, dst);
		chk(srcLineAddr, src);
		stop_test();
	end
endmodule
`default_nettype wire
